// ===== src/sjd_debug_port.sv
// synchronous debug test access port: controller, instruction and data registers,
// debug chain 1 towards the halted core, chain 2 towards the breakpoint unit
// assumes the probe side is synchronised to clock_i and presents a qualifier
`timescale 1ns/1ps
`include "sjd_defines.svh"
module sjd_debug_port
	import sjd_pkg::*;
#(
	parameter logic [31:0] ID_CODE = 32'h1234_5671, // arbitrary identity value
	parameter int          C1_W    = 32,
	parameter int          C2_W    = 38
) (
	input  wire logic              clock_i,                        // master clock
	input  wire logic              rst_i,                          // system reset, async high
	input  wire logic              tap_reset_n_i,                  // TAP reset, async low
	input  wire logic              core_clock_enable_i,            // core clock enable
	input  wire logic              test_clock_qualifier_i,         // test clock qualifier
	input  wire logic              debug_test_mode_select_i,       // mode select
	input  wire logic              debug_test_serial_in_i,         // serial data in
	input  wire logic              external_chain_serial_return_i, // external chain return
	input  wire logic              debug_state_i,                  // core is in debug state
	input  wire logic [C1_W-1:0]   core_data_i,                    // chain 1 capture value
	input  wire logic [31:0]       bpu_rdata_i,                    // breakpoint unit read data
	output logic                   debug_test_serial_out_o,        // serial data out
	output logic                   core_clock_enable_out_o,        // registered clock enable
	output logic      [3:0]        tap_state_code_o,               // controller state code
	output logic      [3:0]        instr_reg_o,                    // current instruction
	output logic      [3:0]        scan_select_o,                  // selected scan chain
	output logic                   system_mode_o,                  // boundary cells pass through
	output logic                   monitor_mode_o,                 // monitor-mode debug enable
	output logic      [C1_W-1:0]   inject_data_o,                  // word for the core
	output logic                   inject_valid_o,                 // one-cycle inject pulse
	output logic                   inject_nop_o,                   // injected word is the nop
	output logic                   restart_o,                      // one-cycle restart pulse
	output logic                   bpu_wr_o,                       // one-cycle write pulse
	output logic      [4:0]        bpu_addr_o,                     // breakpoint unit address
	output logic      [31:0]       bpu_wdata_o                     // breakpoint unit write data
);
	typedef struct packed {
		logic [3:0]      ir;
		logic [3:0]      sel;
		logic            byp;
		logic            tdo;
		logic [3:0]      code;
		logic            cce;
		logic            sysm;
		logic            mon;
		logic [C1_W-1:0] inj;
		logic            inj_v;
		logic            inj_nop;
		logic            rst_pulse;
		logic            wr;
		logic [4:0]      addr;
		logic [31:0]     wdata;
	} sjd_port_s;

	sjd_port_s       p_r;
	sjd_port_s       p_nxt;
	logic            tap_rst;
	sjd_tap_state_e  st;
	sjd_tap_state_e  st_nxt;
	logic            en;
	logic            id_sel;
	logic            sn_sel;
	logic            c1_sel;
	logic            c2_sel;
	logic            ext_sel;
	logic            scan_ir;
	logic [3:0]      ir_q;
	logic [3:0]      sel_q;
	logic [31:0]     id_q;
	logic [C1_W-1:0] c1_q;
	logic [C2_W-1:0] c2_q;
	logic [31:0]     rd_mux;
	logic [C2_W-1:0] c2_cap;

	// =============================================================
	// reset merge and controller
	// the TAP reset needs no qualified edge, so it joins the async reset path
	assign tap_rst = rst_i | ~tap_reset_n_i; // [RULE12] [RULE13] [RULE16]
	// the qualifier is looked at on every edge; it replaces an asynchronous test clock
	assign en      = test_clock_qualifier_i; // [RULE2] [RULE5]

	sjd_tap_fsm u_fsm (
		.clock_i   (clock_i),
		.tap_rst_i (tap_rst),
		.qual_i    (en),
		.tms_i     (debug_test_mode_select_i),
		.state_o   (st),
		.next_o    (st_nxt)
	);

	// =============================================================
	// data register selection; unknown codes and restart fall to bypass
	assign scan_ir = (p_r.ir == `SJD_IR_INTEST) || (p_r.ir == `SJD_IR_EXTEST);
	assign id_sel  = (p_r.ir == `SJD_IR_IDCODE);
	assign sn_sel  = (p_r.ir == `SJD_IR_SCAN_N);
	assign c1_sel  = scan_ir && (p_r.sel == `SJD_SEL_CHAIN1);
	assign c2_sel  = scan_ir && (p_r.sel == `SJD_SEL_CHAIN2);
	assign ext_sel = (scan_ir && !c1_sel && !c2_sel) || (p_r.ir == `SJD_IR_SAMPLE);

	// =============================================================
	// shift registers
	sjd_shift_chain #(.W(4)) u_ir (
		.clock_i   (clock_i),
		.tap_rst_i (tap_rst),
		.capture_i (en && st == ST_CAP_IR),
		.shift_i   (en && st == ST_SH_IR),
		.cap_val_i (`SJD_IR_CAPTURE), // [RULE17]
		.sin_i     (debug_test_serial_in_i),
		.q_o       (ir_q)
	);

	sjd_shift_chain #(.W(4)) u_sel (
		.clock_i   (clock_i),
		.tap_rst_i (tap_rst),
		.capture_i (en && sn_sel && st == ST_CAP_DR),
		.shift_i   (en && sn_sel && st == ST_SH_DR),
		.cap_val_i (`SJD_SEL_CAPTURE),
		.sin_i     (debug_test_serial_in_i),
		.q_o       (sel_q)
	);

	sjd_shift_chain #(.W(32)) u_id (
		.clock_i   (clock_i),
		.tap_rst_i (tap_rst),
		.capture_i (en && id_sel && st == ST_CAP_DR), // [RULE18]
		.shift_i   (en && id_sel && st == ST_SH_DR),
		.cap_val_i (ID_CODE),
		.sin_i     (debug_test_serial_in_i),
		.q_o       (id_q)
	);

	sjd_shift_chain #(.W(C1_W)) u_c1 (
		.clock_i   (clock_i),
		.tap_rst_i (tap_rst),
		.capture_i (en && c1_sel && st == ST_CAP_DR),
		.shift_i   (en && c1_sel && st == ST_SH_DR),
		.cap_val_i (core_data_i),
		.sin_i     (debug_test_serial_in_i),
		.q_o       (c1_q)
	);

	// the control register's monitor bit lives here, so reads see this copy
	always_comb
	begin
		rd_mux = bpu_rdata_i;
		if (p_r.addr == `SJD_DCTRL_ADDR)
			rd_mux[`SJD_DCTRL_MON] = p_r.mon;
		c2_cap = {1'b0, p_r.addr, rd_mux};
	end

	sjd_shift_chain #(.W(C2_W)) u_c2 (
		.clock_i   (clock_i),
		.tap_rst_i (tap_rst),
		.capture_i (en && c2_sel && st == ST_CAP_DR), // [RULE9]
		.shift_i   (en && c2_sel && st == ST_SH_DR),
		.cap_val_i (c2_cap),
		.sin_i     (debug_test_serial_in_i),
		.q_o       (c2_q)
	);

	// =============================================================
	// port state
	always_comb
	begin
		p_nxt         = p_r;
		p_nxt.inj_v   = 1'b0;
		p_nxt.inj_nop = 1'b0;
		p_nxt.wr      = 1'b0;
		p_nxt.rst_pulse = 1'b0;
		p_nxt.cce     = core_clock_enable_i; // [RULE2] [RULE4]
		p_nxt.code    = sjd_state_code(st_nxt); // [RULE10]
		if (en)
		begin
			if (st == ST_CAP_DR && !id_sel && !sn_sel && !c1_sel && !c2_sel)
				p_nxt.byp = 1'b0;
			else if (st == ST_SH_DR)
				p_nxt.byp = debug_test_serial_in_i;
			// serial out is registered; external chains pass through one flop
			if (st == ST_SH_IR)
				p_nxt.tdo = ir_q[0];
			else if (st == ST_SH_DR)
			begin
				if (id_sel)
					p_nxt.tdo = id_q[0]; // [RULE15]
				else if (sn_sel)
					p_nxt.tdo = sel_q[0];
				else if (c1_sel)
					p_nxt.tdo = c1_q[0];
				else if (c2_sel)
					p_nxt.tdo = c2_q[0];
				else if (ext_sel)
					p_nxt.tdo = external_chain_serial_return_i; // [RULE4]
				else
					p_nxt.tdo = p_r.byp;
			end
			if (st == ST_UPD_IR)
			begin
				p_nxt.ir   = ir_q;
				p_nxt.sysm = !((ir_q == `SJD_IR_INTEST) || (ir_q == `SJD_IR_EXTEST));
			end
			if (st == ST_UPD_DR && sn_sel)
				p_nxt.sel = sel_q;
			// chain 1 updates are dropped unless the core is halted
			if (st == ST_UPD_DR && c1_sel && debug_state_i) // [RULE8]
			begin
				p_nxt.inj     = c1_q;
				p_nxt.inj_v   = 1'b1;
				p_nxt.inj_nop = (c1_q[31:0] == `SJD_NOP_OPCODE); // [RULE7]
			end
			if (st == ST_UPD_DR && c2_sel) // [RULE9]
			begin
				p_nxt.addr = c2_q[`SJD_C2_ADDR_MSB:`SJD_C2_ADDR_LSB];
				if (c2_q[`SJD_C2_RW_BIT])
				begin
					p_nxt.wr    = 1'b1;
					p_nxt.wdata = c2_q[`SJD_C2_DATA_MSB:0];
					if (c2_q[`SJD_C2_ADDR_MSB:`SJD_C2_ADDR_LSB] == `SJD_DCTRL_ADDR)
						p_nxt.mon = c2_q[`SJD_DCTRL_MON]; // [RULE6]
				end
			end
			if (st_nxt == ST_RTI && st != ST_RTI && p_r.ir == `SJD_IR_RESTART)
				p_nxt.rst_pulse = 1'b1;
		end
	end

	always_ff @(posedge clock_i or posedge tap_rst) // [RULE1]
	begin
		if (tap_rst)
		begin
			p_r       <= '0;
			p_r.ir    <= `SJD_IR_IDCODE; // [RULE15]
			p_r.sel   <= `SJD_SEL_RESET;
			p_r.code  <= `SJD_ST_TLR;
			p_r.sysm  <= 1'b1; // [RULE14]
			p_r.mon   <= 1'b1; // [RULE6]
		end
		else
			p_r <= p_nxt;
	end

	assign debug_test_serial_out_o = p_r.tdo;
	assign core_clock_enable_out_o = p_r.cce;
	assign tap_state_code_o        = p_r.code;
	assign instr_reg_o             = p_r.ir;
	assign scan_select_o           = p_r.sel;
	assign system_mode_o           = p_r.sysm;
	assign monitor_mode_o          = p_r.mon;
	assign inject_data_o           = p_r.inj;
	assign inject_valid_o          = p_r.inj_v;
	assign inject_nop_o            = p_r.inj_nop;
	assign restart_o               = p_r.rst_pulse;
	assign bpu_wr_o                = p_r.wr;
	assign bpu_addr_o              = p_r.addr;
	assign bpu_wdata_o             = p_r.wdata;

	// =============================================================
	// assertions
	property p_hold_unqualified;
		@(posedge clock_i) disable iff (tap_rst)
		!test_clock_qualifier_i |=> $stable(tap_state_code_o) && $stable(instr_reg_o);
	endproperty
	a_hold_unqualified: assert property (p_hold_unqualified) // [RULE3]
		else $error("port state moved on an unqualified edge");

	property p_reset_state;
		@(posedge clock_i) disable iff (rst_i)
		!tap_reset_n_i |-> tap_state_code_o == `SJD_ST_TLR;
	endproperty
	a_reset_state: assert property (p_reset_state) // [RULE16]
		else $error("controller not in reset while TAP reset low");

	property p_reset_idcode;
		@(posedge clock_i) disable iff (rst_i)
		!tap_reset_n_i |-> instr_reg_o == `SJD_IR_IDCODE && system_mode_o;
	endproperty
	a_reset_idcode: assert property (p_reset_idcode) // [RULE15]
		else $error("reset did not select identity instruction in system mode");

	property p_reset_monitor;
		@(posedge clock_i) disable iff (rst_i)
		$rose(tap_reset_n_i) |-> monitor_mode_o ##1 monitor_mode_o;
	endproperty
	a_reset_monitor: assert property (p_reset_monitor) // [RULE6]
		else $error("monitor mode not selected after TAP reset");

	property p_clock_enable_out;
		@(posedge clock_i) disable iff (tap_rst)
		!$past(tap_rst) |-> core_clock_enable_out_o == $past(core_clock_enable_i);
	endproperty
	a_clock_enable_out: assert property (p_clock_enable_out) // [RULE2]
		else $error("clock enable out does not follow clock enable");

	property p_inject_halted;
		@(posedge clock_i) disable iff (tap_rst)
		inject_valid_o |-> $past(debug_state_i) && scan_select_o == `SJD_SEL_CHAIN1;
	endproperty
	a_inject_halted: assert property (p_inject_halted) // [RULE8]
		else $error("chain 1 injected while core not halted");

	property p_five_ones_reset;
		@(posedge clock_i) disable iff (tap_rst)
		(test_clock_qualifier_i && debug_test_mode_select_i)[*5] |=>
			tap_state_code_o == `SJD_ST_TLR;
	endproperty
	a_five_ones_reset: assert property (p_five_ones_reset) // [RULE19]
		else $error("five qualified ones did not reach reset state");

	property p_ext_return;
		@(posedge clock_i) disable iff (tap_rst)
		(en && st == ST_SH_DR && ext_sel) |=>
			debug_test_serial_out_o == $past(external_chain_serial_return_i);
	endproperty
	a_ext_return: assert property (p_ext_return) // [RULE4]
		else $error("serial out does not follow external chain return");

	property p_bpu_write;
		@(posedge clock_i) disable iff (tap_rst)
		bpu_wr_o |-> $past(st == ST_UPD_DR && c2_sel && en);
	endproperty
	a_bpu_write: assert property (p_bpu_write) // [RULE9]
		else $error("breakpoint unit write without chain 2 update");

	property p_ir_capture;
		@(posedge clock_i) disable iff (tap_rst)
		(en && st == ST_CAP_IR) |=> ir_q == `SJD_IR_CAPTURE;
	endproperty
	a_ir_capture: assert property (p_ir_capture) // [RULE17]
		else $error("instruction register did not capture fixed pattern");

	c_inject:  cover property (@(posedge clock_i) disable iff (tap_rst) inject_valid_o);
	c_nop:     cover property (@(posedge clock_i) disable iff (tap_rst) inject_nop_o);
	c_bpu_wr:  cover property (@(posedge clock_i) disable iff (tap_rst) bpu_wr_o);
	c_restart: cover property (@(posedge clock_i) disable iff (tap_rst) restart_o);
endmodule : sjd_debug_port

// ===== src/sjd_defines.svh
// constants of the synchronous debug test port: codes, fixed patterns, field positions
// assumes every file that needs a constant includes this header by its bare name
// What this block does
// [RULE1] every input is sampled only on the rising master clock edge; rst_i and tap_reset_n_i act asynchronously here
// [RULE2] both clock enables are sampled on every rising edge, asserted or not
// [RULE3] mode select and serial in are taken only on qualified edges
// [RULE4] outputs launch from the clock edge; serial out and clock enable out follow sources
// [RULE5] an asynchronous test clock is synchronised outside; master clock keeps running
// [RULE6] test reset starts monitor-mode debug; clearing the enable bit gives halt mode
// [RULE7] the special opcode is flagged as a single-cycle non-interlocking no-operation
// [RULE8] debug chain 1 acts only while the core is in debug state
// [RULE9] debug chain 2 reads and writes the breakpoint and watchpoint unit registers
// [RULE10] the controller state is driven continuously as a 4-bit code
// [RULE11] after power-up the probe pulses the TAP reset low, then high
// [RULE12] holding the TAP reset low keeps the port disabled
// [RULE13] TAP reset acts with no qualified clock edge
// [RULE14] TAP reset selects system mode; boundary cells pass all signals
// [RULE15] TAP reset selects IDCODE; shift-DR then shifts the identity word out
// [RULE16] TAP reset asserts asynchronously, forcing the controller to reset at once
// [RULE17] instruction register is four bits, no parity, captures 0001
// [RULE18] identity register is 32 bits and readable through the port
// [RULE19] controller follows the sixteen-state graph, one step per qualified edge
// [RULE20] the probe holds select and data stable around qualified edges
`ifndef SJD_DEFINES_SVH
`define SJD_DEFINES_SVH

// =============================================================
// instruction codes, capture patterns, scan chain numbers and the nop opcode
`define SJD_IR_EXTEST    4'h0
`define SJD_IR_SCAN_N    4'h2
`define SJD_IR_SAMPLE    4'h3
`define SJD_IR_RESTART   4'h4
`define SJD_IR_INTEST    4'hc
`define SJD_IR_IDCODE    4'he
`define SJD_IR_BYPASS    4'hf
`define SJD_IR_CAPTURE   4'h1
`define SJD_SEL_CAPTURE  4'h8
`define SJD_SEL_RESET    4'h0
`define SJD_SEL_CHAIN1   4'h1
`define SJD_SEL_CHAIN2   4'h2
`define SJD_NOP_OPCODE   32'he320f000

// =============================================================
// controller state codes
`define SJD_ST_TLR       4'hf
`define SJD_ST_RTI       4'hc
`define SJD_ST_SEL_DR    4'h7
`define SJD_ST_CAP_DR    4'h6
`define SJD_ST_SH_DR     4'h2
`define SJD_ST_EX1_DR    4'h1
`define SJD_ST_PAU_DR    4'h3
`define SJD_ST_EX2_DR    4'h0
`define SJD_ST_UPD_DR    4'h5
`define SJD_ST_SEL_IR    4'h4
`define SJD_ST_CAP_IR    4'he
`define SJD_ST_SH_IR     4'ha
`define SJD_ST_EX1_IR    4'h9
`define SJD_ST_PAU_IR    4'hb
`define SJD_ST_EX2_IR    4'h8
`define SJD_ST_UPD_IR    4'hd

// =============================================================
// chain 2 layout: {write, address, data}
`define SJD_C2_RW_BIT    37
`define SJD_C2_ADDR_MSB  36
`define SJD_C2_ADDR_LSB  32
`define SJD_C2_DATA_MSB  31
`define SJD_DCTRL_ADDR   5'h00
`define SJD_DCTRL_MON    4

`endif

// ===== src/sjd_pkg.sv
// types of the synchronous debug test port
// assumes sjd_defines.svh is on the include path
`include "sjd_defines.svh"
package sjd_pkg;
	typedef enum logic [3:0] {
		ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
		ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
	} sjd_tap_state_e;

	function automatic logic [3:0] sjd_state_code(input sjd_tap_state_e s);
		unique case (s)
			ST_TLR:    return `SJD_ST_TLR;
			ST_RTI:    return `SJD_ST_RTI;
			ST_SEL_DR: return `SJD_ST_SEL_DR;
			ST_CAP_DR: return `SJD_ST_CAP_DR;
			ST_SH_DR:  return `SJD_ST_SH_DR;
			ST_EX1_DR: return `SJD_ST_EX1_DR;
			ST_PAU_DR: return `SJD_ST_PAU_DR;
			ST_EX2_DR: return `SJD_ST_EX2_DR;
			ST_UPD_DR: return `SJD_ST_UPD_DR;
			ST_SEL_IR: return `SJD_ST_SEL_IR;
			ST_CAP_IR: return `SJD_ST_CAP_IR;
			ST_SH_IR:  return `SJD_ST_SH_IR;
			ST_EX1_IR: return `SJD_ST_EX1_IR;
			ST_PAU_IR: return `SJD_ST_PAU_IR;
			ST_EX2_IR: return `SJD_ST_EX2_IR;
			default:   return `SJD_ST_UPD_IR;
		endcase
	endfunction : sjd_state_code
endpackage : sjd_pkg

// ===== src/sjd_shift_chain.sv
// serial chain with parallel capture, shifting towards bit 0
// assumes capture and shift are never high together
`timescale 1ns/1ps
module sjd_shift_chain #(
	parameter int W = 32
) (
	input  wire logic          clock_i,   // master clock
	input  wire logic          tap_rst_i, // async reset, active high
	input  wire logic          capture_i, // load cap_val_i this edge
	input  wire logic          shift_i,   // shift one place this edge
	input  wire logic [W-1:0]  cap_val_i, // parallel capture value
	input  wire logic          sin_i,     // serial in
	output logic      [W-1:0]  q_o        // chain contents, q_o[0] goes out next
);
	typedef struct packed {
		logic [W-1:0] q;
	} sjd_chain_s;

	sjd_chain_s  ch_r;
	sjd_chain_s  ch_nxt;

	always_comb
	begin
		ch_nxt = ch_r;
		if (capture_i)
			ch_nxt.q = cap_val_i;
		else if (shift_i)
			ch_nxt.q = {sin_i, ch_r.q[W-1:1]};
	end

	always_ff @(posedge clock_i or posedge tap_rst_i)
	begin
		if (tap_rst_i)
			ch_r <= '0;
		else
			ch_r <= ch_nxt;
	end

	assign q_o = ch_r.q;
endmodule : sjd_shift_chain

// ===== src/sjd_tap_fsm.sv
// test access port controller: sixteen states, one step per qualified edge
// assumes tap_rst_i already merges the system reset and the TAP reset
`timescale 1ns/1ps
module sjd_tap_fsm
	import sjd_pkg::*;
(
	input  wire logic           clock_i,  // master clock
	input  wire logic           tap_rst_i, // async reset, active high
	input  wire logic           qual_i,   // test clock qualifier
	input  wire logic           tms_i,    // mode select
	output sjd_tap_state_e      state_o,  // current state
	output sjd_tap_state_e      next_o    // state after this edge
);
	typedef struct packed {
		sjd_tap_state_e st;
	} sjd_fsm_s;

	sjd_fsm_s        fsm_r;
	sjd_fsm_s        fsm_nxt;
	sjd_tap_state_e  step;

	// =============================================================
	// transition graph
	always_comb
	begin
		unique case (fsm_r.st)
			ST_TLR:    step = tms_i ? ST_TLR    : ST_RTI;
			ST_RTI:    step = tms_i ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: step = tms_i ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: step = tms_i ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR:  step = tms_i ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: step = tms_i ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: step = tms_i ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: step = tms_i ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: step = tms_i ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: step = tms_i ? ST_TLR    : ST_CAP_IR;
			ST_CAP_IR: step = tms_i ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR:  step = tms_i ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: step = tms_i ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: step = tms_i ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: step = tms_i ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: step = tms_i ? ST_SEL_DR : ST_RTI;
		endcase
		fsm_nxt = fsm_r;
		if (qual_i) // [RULE3] [RULE19]
			fsm_nxt.st = step;
	end

	always_ff @(posedge clock_i or posedge tap_rst_i) // [RULE1] [RULE16]
	begin
		if (tap_rst_i)
			fsm_r <= '{st: ST_TLR};
		else
			fsm_r <= fsm_nxt;
	end

	assign state_o = fsm_r.st;
	assign next_o  = fsm_nxt.st;
endmodule : sjd_tap_fsm

// ===== testbench/sjd_probe.sv
// debugger probe model: drives select, data and qualifier, one qualified edge per step
// assumes the port samples select and data only on qualified rising edges of clock_i
`timescale 1ns/1ps
module sjd_probe (
	input  wire logic clock_i, // master clock, kept running
	input  wire logic tdo_i,   // serial out of the port
	output logic      tms_o,   // mode select
	output logic      tdi_o,   // serial in
	output logic      qual_o   // test clock qualifier
);
	// =============================================================
	// stepping
	int gap = 0; // idle cycles before each step, for a slow probe
	initial
	begin
		tms_o  = 1'b1;
		tdi_o  = 1'b0;
		qual_o = 1'b0;
	end
	task automatic step(input logic t, input logic d, output logic o);
		repeat (gap) @(posedge clock_i);
		@(posedge clock_i);
		qual_o <= 1'b1;
		tms_o  <= t;
		tdi_o  <= d;
		@(posedge clock_i);
		qual_o <= 1'b0;
		// lines flip between steps so an unqualified sample shows up
		tms_o  <= ~t;
		tdi_o  <= ~d;
		#1 o = tdo_i;
	endtask : step
	// qualifier held high for n edges in a row with select high, as a fast probe does
	task automatic burst(input int n);
		@(posedge clock_i);
		qual_o <= 1'b1;
		tms_o  <= 1'b1;
		repeat (n) @(posedge clock_i);
		qual_o <= 1'b0;
	endtask : burst
endmodule : sjd_probe

// ===== testbench/tb_top.sv
// self-checking bench of the debug test port, driven through the probe model
// assumes the probe model and the design files are compiled first
`timescale 1ns/1ps
`include "sjd_defines.svh"
module tb_top;
	import sjd_pkg::*;
	logic clock_i = 1'b0, rst_i = 1'b1, tap_reset_n_i = 1'b0, cce = 1'b0, dbg = 1'b0;
	logic tms, tdi, qual, tdo, cce_out, sysm, mon, inj_v, inj_nop, rst_p, wr, ext_ret;
	logic [3:0] st, ir, sel;
	logic [4:0] addr;
	logic [31:0] wdata, inj_d, rdata;
	int fail_count = 0, total_checks = 0, n_inj = 0, n_nop = 0, n_wr = 0, n_rs = 0;
	logic [63:0] o;
	always #2 clock_i = ~clock_i;
	assign rdata = {27'h0, addr} ^ 32'ha5a5_0000;
	// external chain model: an inverting loopback, so a stuck return cannot pass
	assign ext_ret = ~tdi;
	always @(posedge clock_i)
	begin
		n_inj += (inj_v === 1'b1);
		n_nop += (inj_v === 1'b1 && inj_nop === 1'b1);
		n_wr  += (wr === 1'b1);
		n_rs  += (rst_p === 1'b1);
	end
	sjd_probe i_sjd_probe (.clock_i(clock_i), .tdo_i(tdo), .tms_o(tms), .tdi_o(tdi), .qual_o(qual));
	sjd_debug_port i_sjd_debug_port (.clock_i(clock_i), .rst_i(rst_i),
		.tap_reset_n_i(tap_reset_n_i), .core_clock_enable_i(cce), .test_clock_qualifier_i(qual),
		.debug_test_mode_select_i(tms), .debug_test_serial_in_i(tdi),
		.external_chain_serial_return_i(ext_ret), .debug_state_i(dbg), .core_data_i(32'h0bad_f00d),
		.bpu_rdata_i(rdata), .debug_test_serial_out_o(tdo), .core_clock_enable_out_o(cce_out),
		.tap_state_code_o(st), .instr_reg_o(ir), .scan_select_o(sel), .system_mode_o(sysm),
		.monitor_mode_o(mon), .inject_data_o(inj_d), .inject_valid_o(inj_v),
		.inject_nop_o(inj_nop), .restart_o(rst_p), .bpu_wr_o(wr), .bpu_addr_o(addr),
		.bpu_wdata_o(wdata));
	// =============================================================
	// helpers
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk
	task automatic step(input logic t, input logic d = 1'b0);
		logic b;
		i_sjd_probe.step(t, d, b);
	endtask : step
	task automatic shift(input int n, input logic [63:0] d, output logic [63:0] q);
		logic b;
		q = '0;
		for (int i = 0; i < n; i++)
		begin
			i_sjd_probe.step(i == n - 1, d[i], b);
			q[i] = b;
		end
		step(1'b1);
		step(1'b0);
	endtask : shift
	task automatic ir_load(input logic [3:0] c, output logic [63:0] q);
		step(1'b1); step(1'b1); step(1'b0); step(1'b0);
		shift(4, {60'h0, c}, q);
	endtask : ir_load
	task automatic dr(input int n, input logic [63:0] d, output logic [63:0] q);
		step(1'b1); step(1'b0); step(1'b0);
		shift(n, d, q);
	endtask : dr
	task automatic chk_reset();
		chk("state", 4'hf, st);
		chk("ir", 4'he, ir);
		chk("sysmode", 1, sysm);
		chk("monitor", 1, mon);
	endtask : chk_reset
	// =============================================================
	// scenarios
	task automatic sc_id_read();
		step(1'b0); chk("rti", 4'hc, st);
		dr(32, 64'h0, o);
		chk("idcode", 32'h1234_5671, o);
		chk("rti2", 4'hc, st);
	endtask : sc_id_read
	task automatic sc_idle();
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clock_i) cce <= i[0];
			@(posedge clock_i) #1;
			chk("cce_out", i[0], cce_out);
			chk("state held", 4'hc, st);
		end
		i_sjd_probe.burst(5);
		#1 chk("five ones", `SJD_ST_TLR, st);
		step(1'b0);
	endtask : sc_idle
	task automatic sc_chain2();
		ir_load(`SJD_IR_SCAN_N, o); chk("ir cap", 4'h1, o);
		dr(4, 64'h2, o); chk("scan_n cap", 4'h8, o);
		chk("select", 4'h2, sel);
		ir_load(`SJD_IR_INTEST, o); chk("sysmode", 0, sysm);
		dr(38, {26'h0, 1'b1, 5'h00, 32'h0}, o);
		chk("monitor", 0, mon);
		dr(38, {26'h0, 1'b1, 5'h08, 32'hdead_beef}, o);
		chk("wdata", 32'hdead_beef, wdata);
		chk("addr", 5'h08, addr);
		dr(38, {26'h0, 1'b0, 5'h08, 32'h0}, o);
		chk("c2 read", {1'b0, 5'h08, 32'ha5a5_0008}, o[37:0]);
		chk("wr pulses", 2, n_wr);
	endtask : sc_chain2
	task automatic sc_chain1();
		i_sjd_probe.gap = 2;
		ir_load(`SJD_IR_SCAN_N, o);
		dr(4, 64'h1, o);
		ir_load(`SJD_IR_INTEST, o);
		dr(32, `SJD_NOP_OPCODE, o); chk("no inject", 0, n_inj);
		chk("c1 cap", 32'h0bad_f00d, o);
		@(posedge clock_i) dbg <= 1'b1;
		dr(32, `SJD_NOP_OPCODE, o); chk("inject", 1, inj_v);
		chk("nop", 1, inj_nop); chk("inj data", `SJD_NOP_OPCODE, inj_d);
		@(posedge clock_i) #1 chk("inject count", 1, n_inj);
		chk("nop count", 1, n_nop);
		i_sjd_probe.gap = 0;
		ir_load(`SJD_IR_RESTART, o);
		dr(1, 64'h1, o); chk("bypass cap", 0, o[0]);
		chk("restart", 1, rst_p);
		@(posedge clock_i) #1 chk("restart count", 1, n_rs);
	endtask : sc_chain1
	task automatic sc_ext();
		ir_load(`SJD_IR_SAMPLE, o); chk("ext sysmode", 1, sysm);
		dr(8, 64'h3c, o); chk("ext return", 64'hc3, o);
	endtask : sc_ext
	task automatic sc_async_reset();
		// reset lands just after an edge; outputs must move before the next one
		@(posedge clock_i) tap_reset_n_i <= 1'b0;
		#1 chk_reset();
		step(1'b0); chk_reset();
		@(posedge clock_i) tap_reset_n_i <= 1'b1;
		step(1'b0); chk("rti3", 4'hc, st);
	endtask : sc_async_reset
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	// =============================================================
	// main sequence and watchdog
	initial
	begin
		repeat (20) @(posedge clock_i);
		rst_i <= 1'b0;
		tap_reset_n_i <= 1'b1;
		@(posedge clock_i) #1 chk_reset();
		sc_id_read();
		sc_idle();
		sc_chain2();
		sc_async_reset();
		sc_chain1();
		sc_ext();
		summarize();
	end
	initial
	begin
		repeat (20000) @(posedge clock_i);
		fail_count++;
		summarize();
	end
endmodule : tb_top
